// ==== hw/bert_top.sv ====
// Purpose: bit error rate tester with APB registers and a serial payload path
// Assumes: payload bits arrive and leave one per strobe, synchronous to pclk
// Notes:   receive side is always enabled and can monitor off-line
//
// Overview of operation
// [R1] generate and lock to x^n+x^y+1 sequences, n 1..32, any seed
// [R2] repetitive patterns of 1 to 32 bits from the seed value
// [R3] 24-bit error count and 32-bit bit count readable by software
// [R4] errors inserted singly by register, by pin transition, or one per 10^n bits
// [R5] lock holds under a one in a thousand random error rate
// [R6] software enables the tester before a load; loads while disabled do nothing
// [R7] a zero to one write on a load bit loads that generator
// [R8] error count nonzero status is set while the error count is one or more
// [R9] out of sync while unlocked; six errors in a 64-bit window lose lock
// [R10] an update event copies running counts to readable registers and clears them
// [R11] pattern word: tap 12:8, length 4:0, repetitive select 5, qrss 6
// [R12] separate transmit and receive pattern inversion
// [R13] qrss uses taps 17 and 20 and forces a one after fourteen zeros
// [R14] polynomial feedback forced to one when bits 1 to 31 are zero
// [R15] lock: load 32 incoming bits, then all next 32 must match
// [R16] no counting while out of sync

`timescale 1ns/1ps

module bert_top
    import bert_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        datapath_reset,
    input  wire logic        pmu_update,
    input  wire logic        manual_error_input_pin,
    input  wire logic        tx_bit_req,
    output logic             tx_bit_valid,
    output logic             tx_bit,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    output logic             irq
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic                  pready_q;
    logic                  pslverr_q;
    logic [31:0]           prdata_q;
    wire                   acc_first;
    wire                   wr_take;
    wire                   hit_port;
    wire                   hit_pcw;
    wire                   hit_slo;
    wire                   hit_shi;
    wire                   hit_ctl;
    wire                   hit_sts;
    wire                   hit_ist;
    wire                   hit_msk;
    wire                   hit_bcnt;
    wire                   hit_ecnt;
    wire                   addr_hit;
    logic [31:0]           rd_mux;

    assign acc_first = psel & penable & ~pready_q;
    assign wr_take   = psel & penable & pready_q & pwrite & ~pslverr_q;
    assign hit_port  = (paddr == OFS_PORT_CTL);
    assign hit_pcw   = (paddr == OFS_PAT_CTL);
    assign hit_slo   = (paddr == OFS_SEED_LO);
    assign hit_shi   = (paddr == OFS_SEED_HI);
    assign hit_ctl   = (paddr == OFS_TST_CTL);
    assign hit_sts   = (paddr == OFS_TST_STS);
    assign hit_ist   = (paddr == OFS_INT_STS);
    assign hit_msk   = (paddr == OFS_INT_MASK);
    assign hit_bcnt  = (paddr == OFS_BIT_CNT);
    assign hit_ecnt  = (paddr == OFS_ERR_CNT);
    assign addr_hit  = hit_port | hit_pcw | hit_slo | hit_shi | hit_ctl | hit_sts
                     | hit_ist | hit_msk | hit_bcnt | hit_ecnt;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic                  en_q;
    logic [PCW_WIDTH-1:0]  pcw_q;
    logic [15:0]           seed_lo_q;
    logic [15:0]           seed_hi_q;
    logic [CTL_WIDTH-1:0]  ctl_q;
    logic [INT_WIDTH-1:0]  ist_q;
    logic [INT_WIDTH-1:0]  ist_d;
    logic [INT_WIDTH-1:0]  msk_q;
    logic [31:0]           bit_cnt_q;
    logic [ERR_W-1:0]      err_cnt_q;
    logic                  bec_q;
    logic                  oos_q;
    wire                   wr_ctl;
    wire                   tx_load;
    wire                   rx_load;
    wire                   sw_update;
    wire                   sw_err;
    wire                   tx_inv;
    wire                   rx_inv;
    wire                   err_from_pin;
    wire                   no_resync;
    wire [2:0]             rate_n;

    assign wr_ctl       = wr_take & hit_ctl;
    // only the rising write of a load bit acts, and only while enabled
    assign tx_load      = wr_ctl & pwdata[CTL_TX_LOAD] & ~ctl_q[CTL_TX_LOAD] & en_q; // R6 R7
    assign rx_load      = wr_ctl & pwdata[CTL_RX_LOAD] & ~ctl_q[CTL_RX_LOAD] & en_q; // R6 R7
    assign sw_update    = wr_ctl & pwdata[CTL_UPDATE] & ~ctl_q[CTL_UPDATE];
    assign sw_err       = wr_ctl & pwdata[CTL_SW_ERR];
    assign tx_inv       = ctl_q[CTL_TX_INV];                                  // R12
    assign rx_inv       = ctl_q[CTL_RX_INV];                                  // R12
    assign err_from_pin = ctl_q[CTL_ERR_PIN];
    assign no_resync    = ctl_q[CTL_NO_RESYNC];
    assign rate_n       = ctl_q[CTL_RATE_LSB +: 3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 1'b0;
            pcw_q     <= PCW_RESET;
            seed_lo_q <= SEED_RESET;
            seed_hi_q <= SEED_RESET;
            ctl_q     <= '0;
            msk_q     <= '0;
        end else if (wr_take) begin
            if (hit_port) en_q      <= pwdata[0];
            if (hit_pcw)  pcw_q     <= pwdata[PCW_WIDTH-1:0];
            if (hit_slo)  seed_lo_q <= pwdata[15:0];
            if (hit_shi)  seed_hi_q <= pwdata[15:0];
            if (hit_ctl)  ctl_q     <= pwdata[CTL_WIDTH-1:0] & ~(12'h1 << CTL_SW_ERR);
            if (hit_msk)  msk_q     <= pwdata[INT_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // pattern generators
    // ------------------------------------------------------------
    bert_gen_if tg ();
    bert_gen_if rg ();
    wire [31:0] seed_word;
    wire        rx_in;
    wire        rx_miss;
    logic       ins_now;

    assign seed_word = {seed_hi_q, seed_lo_q};                                // R1 R2
    // pattern control layout
    assign tg.len    = pcw_q[PCW_LEN_LSB +: 5];                               // R11
    assign tg.tap    = pcw_q[PCW_TAP_LSB +: 5];                               // R11
    assign tg.rep    = pcw_q[PCW_REP_BIT];                                    // R11
    assign tg.qrss   = pcw_q[PCW_QRSS_BIT];                                   // R11
    assign tg.load   = tx_load;
    assign tg.seed   = seed_word;
    assign tg.step   = tx_bit_req & ~tx_load;
    assign tg.use_ext = 1'b0;
    assign tg.ext_bit = 1'b0;

    assign rg.len    = tg.len;
    assign rg.tap    = tg.tap;
    assign rg.rep    = tg.rep;
    assign rg.qrss   = tg.qrss;
    assign rg.load   = rx_load;
    assign rg.seed   = seed_word;
    assign rg.step   = rx_bit_valid & ~rx_load;
    // loading de-inverts the incoming bit so the generator holds true pattern
    assign rx_in     = rx_bit ^ rx_inv;                                       // R12
    assign rg.ext_bit = rx_in;
    assign rx_miss   = rx_in ^ rg.out_bit;

    bert_pgen u_tx_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .g       (tg.gen)
    );

    bert_pgen u_rx_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .g       (rg.gen)
    );

    // ------------------------------------------------------------
    // transmit error insertion
    // ------------------------------------------------------------
    logic              pin_q;
    logic              pend_q;
    logic [RATE_W-1:0] rate_cnt_q;
    logic              tx_bit_q;
    logic              tx_vld_q;
    wire               pin_edge;
    wire               single_req;
    wire [RATE_W-1:0]  rate_div;
    wire               rate_on;
    wire               rate_hit;

    assign pin_edge   = manual_error_input_pin ^ pin_q;
    assign single_req = err_from_pin ? pin_edge : sw_err;                     // R4
    assign rate_div   = bert_rate_div(rate_n);
    assign rate_on    = (rate_n != 3'h0);
    assign rate_hit   = rate_on & (rate_cnt_q == rate_div - 24'h000001);      // R4
    assign ins_now    = pend_q | rate_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q      <= 1'b0;
            pend_q     <= 1'b0;
            rate_cnt_q <= '0;
            tx_bit_q   <= 1'b0;
            tx_vld_q   <= 1'b0;
        end else begin
            pin_q    <= manual_error_input_pin;
            // a new request in the consuming cycle stays pending
            pend_q   <= single_req | (pend_q & ~tx_bit_req);                  // R4
            tx_vld_q <= tx_bit_req;
            if (!rate_on || tx_load) begin
                rate_cnt_q <= '0;
            end else if (tx_bit_req) begin
                rate_cnt_q <= rate_hit ? '0 : rate_cnt_q + 24'h000001;
            end
            if (tx_bit_req) begin
                tx_bit_q <= tg.out_bit ^ tx_inv ^ ins_now;                    // R4 R12
            end
        end
    end

    // ------------------------------------------------------------
    // receive synchroniser
    // ------------------------------------------------------------
    bert_rx_state_e st_q;
    bert_rx_state_e st_d;
    logic [5:0]     cnt_q;
    logic [5:0]     cnt_d;
    logic [2:0]     werr_q;
    logic [2:0]     werr_d;
    wire  [2:0]     werr_inc;
    wire            in_sync;

    assign werr_inc   = (werr_q == LOSS_ERRS) ? werr_q : werr_q + {2'b00, rx_miss};
    assign in_sync    = (st_q == RX_SYNC);
    assign rg.use_ext = (st_q == RX_LOAD);                                    // R15

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        werr_d = werr_q;
        if (rx_load || datapath_reset) begin
            st_d   = RX_LOAD;
            cnt_d  = '0;
            werr_d = '0;
        end else if (rx_bit_valid) begin
            cnt_d = cnt_q + 6'h01;
            unique case (st_q)
                RX_LOAD: begin
                    if (cnt_q == LOAD_LAST) begin                             // R15
                        st_d  = RX_CHECK;
                        cnt_d = '0;
                    end
                end
                RX_CHECK: begin
                    if (rx_miss) begin                                        // R15
                        st_d  = RX_LOAD;
                        cnt_d = '0;
                    end else if (cnt_q == CHECK_LAST) begin
                        st_d   = RX_SYNC;
                        cnt_d  = '0;
                        werr_d = '0;
                    end
                end
                RX_SYNC: begin
                    // threshold of six per 64 tolerates scattered errors
                    werr_d = (cnt_q == WIN_LAST) ? 3'h0 : werr_inc;           // R5 R9
                    if (werr_inc == LOSS_ERRS && !no_resync) begin            // R9
                        st_d   = RX_LOAD;
                        cnt_d  = '0;
                        werr_d = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= RX_LOAD;
            cnt_q  <= '0;
            werr_q <= '0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            werr_q <= werr_d;
        end
    end

    // ------------------------------------------------------------
    // bit and error counters
    // ------------------------------------------------------------
    logic [31:0]      run_bits_q;
    logic [ERR_W-1:0] run_errs_q;
    wire              upd_ev;
    wire              count_en;
    wire [31:0]       bits_nx;
    wire [ERR_W-1:0]  errs_nx;

    assign upd_ev   = sw_update | pmu_update;                                 // R10
    assign count_en = rx_bit_valid & in_sync;                                 // R16
    assign bits_nx  = run_bits_q + 32'h0000_0001;
    assign errs_nx  = (&run_errs_q) ? run_errs_q : run_errs_q + 24'h000001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_bits_q <= '0;
            run_errs_q <= '0;
            bit_cnt_q  <= '0;
            err_cnt_q  <= '0;
        end else if (datapath_reset) begin
            run_bits_q <= '0;
            run_errs_q <= '0;
        end else if (upd_ev) begin
            bit_cnt_q  <= run_bits_q;                                         // R3 R10
            err_cnt_q  <= run_errs_q;                                         // R3 R10
            run_bits_q <= '0;
            run_errs_q <= '0;
        end else if (count_en) begin
            run_bits_q <= bits_nx;                                            // R3
            if (rx_miss) run_errs_q <= errs_nx;                               // R3
        end
    end

    // ------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------
    logic             irq_q;
    wire              bec_now;
    wire [INT_WIDTH-1:0] ev;
    wire [INT_WIDTH-1:0] w1c;

    assign bec_now = (err_cnt_q != '0);                                       // R8
    assign ev[INT_OOS_SET]  = ~oos_q & ~in_sync;
    assign ev[INT_SYNC_SET] = oos_q & in_sync;
    assign ev[INT_BEC_SET]  = bec_now & ~bec_q;
    assign ev[INT_UPDATE]   = upd_ev;
    assign w1c   = (wr_take & hit_ist) ? pwdata[INT_WIDTH-1:0] : '0;
    // an event in the clearing cycle survives
    assign ist_d = (ist_q & ~w1c) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bec_q <= 1'b0;
            oos_q <= 1'b1;
            ist_q <= '0;
            irq_q <= 1'b0;
        end else begin
            bec_q <= bec_now;                                                 // R8
            oos_q <= ~in_sync;                                                // R9
            ist_q <= ist_d;
            irq_q <= |(ist_q & msk_q);
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit_port: rd_mux = {31'h0, en_q};
            hit_pcw:  rd_mux = {19'h0, pcw_q};
            hit_slo:  rd_mux = {16'h0, seed_lo_q};
            hit_shi:  rd_mux = {16'h0, seed_hi_q};
            hit_ctl:  rd_mux = {20'h0, ctl_q};
            hit_sts:  rd_mux = {30'h0, oos_q, bec_q};
            hit_ist:  rd_mux = {28'h0, ist_q};
            hit_msk:  rd_mux = {28'h0, msk_q};
            hit_bcnt: rd_mux = bit_cnt_q;
            hit_ecnt: rd_mux = {8'h0, err_cnt_q};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first & ~addr_hit;
            if (acc_first) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign tx_bit       = tx_bit_q;
    assign tx_bit_valid = tx_vld_q;
    assign irq          = irq_q;

endmodule : bert_top

// ==== hw/bert_pkg.sv ====
// Purpose: constants shared by the bit error rate tester modules
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   field positions follow the pattern control word layout

package bert_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_CTL  = 8'h00;
    localparam logic [7:0] OFS_PAT_CTL   = 8'h04;
    localparam logic [7:0] OFS_SEED_LO   = 8'h08;
    localparam logic [7:0] OFS_SEED_HI   = 8'h0c;
    localparam logic [7:0] OFS_TST_CTL   = 8'h10;
    localparam logic [7:0] OFS_TST_STS   = 8'h14;
    localparam logic [7:0] OFS_INT_STS   = 8'h18;
    localparam logic [7:0] OFS_INT_MASK  = 8'h1c;
    localparam logic [7:0] OFS_BIT_CNT   = 8'h20;
    localparam logic [7:0] OFS_ERR_CNT   = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PCW_LEN_LSB   = 0;
    localparam int PCW_REP_BIT   = 5;
    localparam int PCW_QRSS_BIT  = 6;
    localparam int PCW_TAP_LSB   = 8;
    localparam int PCW_WIDTH     = 13;

    localparam int CTL_TX_LOAD   = 0;
    localparam int CTL_RX_LOAD   = 1;
    localparam int CTL_TX_INV    = 2;
    localparam int CTL_RX_INV    = 3;
    localparam int CTL_UPDATE    = 4;
    localparam int CTL_SW_ERR    = 5;
    localparam int CTL_ERR_PIN   = 6;
    localparam int CTL_RATE_LSB  = 8;
    localparam int CTL_NO_RESYNC = 11;
    localparam int CTL_WIDTH     = 12;

    localparam int STS_BEC       = 0;
    localparam int STS_OOS       = 1;

    localparam int INT_OOS_SET   = 0;
    localparam int INT_SYNC_SET  = 1;
    localparam int INT_BEC_SET   = 2;
    localparam int INT_UPDATE    = 3;
    localparam int INT_WIDTH     = 4;

    // ------------------------------------------------------------
    // reset values and sync figures
    // ------------------------------------------------------------
    localparam logic [PCW_WIDTH-1:0] PCW_RESET  = 13'h0000;
    localparam logic [15:0]          SEED_RESET = 16'hffff;
    localparam logic [5:0]           LOAD_LAST  = 6'h1f;
    localparam logic [5:0]           CHECK_LAST = 6'h1f;
    localparam logic [5:0]           WIN_LAST   = 6'h3f;
    localparam logic [2:0]           LOSS_ERRS  = 3'h6;
    localparam int                   ERR_W      = 24;
    localparam int                   RATE_W     = 24;

    typedef enum logic [1:0] {RX_LOAD, RX_CHECK, RX_SYNC} bert_rx_state_e;

    // one inserted error per ten to the n bits
    function automatic logic [RATE_W-1:0] bert_rate_div(input logic [2:0] n);
        unique case (n)
            3'h1:    bert_rate_div = 24'h00000a;
            3'h2:    bert_rate_div = 24'h000064;
            3'h3:    bert_rate_div = 24'h0003e8;
            3'h4:    bert_rate_div = 24'h002710;
            3'h5:    bert_rate_div = 24'h0186a0;
            3'h6:    bert_rate_div = 24'h0f4240;
            3'h7:    bert_rate_div = 24'h989680;
            default: bert_rate_div = 24'h000000;
        endcase
    endfunction : bert_rate_div

endpackage : bert_pkg

// ==== hw/bert_gen_if.sv ====
// Purpose: carrier between the tester core and a pattern generator
// Assumes: one clock, pclk
// Notes:   ctrl drives settings and steps, gen returns the pattern bit

`timescale 1ns/1ps

interface bert_gen_if;
    logic        load;
    logic [31:0] seed;
    logic [4:0]  len;
    logic [4:0]  tap;
    logic        rep;
    logic        qrss;
    logic        step;
    logic        use_ext;
    logic        ext_bit;
    logic        out_bit;

    modport ctrl (output load, seed, len, tap, rep, qrss, step, use_ext, ext_bit,
                  input  out_bit);
    modport gen  (input  load, seed, len, tap, rep, qrss, step, use_ext, ext_bit,
                  output out_bit);
endinterface : bert_gen_if

// ==== hw/bert_pgen.sv ====
// Purpose: 32-bit pattern generator shared by transmit and receive sides
// Assumes: len and tap hold n-1 and y-1
// Notes:   output is the feedback bit, forced to one after fourteen zeros in qrss; feedback is shifted into bit 0 unless use_ext selects ext_bit

`timescale 1ns/1ps

module bert_pgen
    import bert_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    bert_gen_if.gen  g
);
    logic [31:0] sr_q;
    logic [31:0] sr_d;
    wire         fb_raw;
    wire         fb;
    wire         shift_in;

    assign fb_raw   = g.rep  ? sr_q[g.len]                                  // R2
                    : g.qrss ? (sr_q[16] ^ sr_q[19])                        // R13
                    :          (sr_q[g.len] ^ sr_q[g.tap]);                 // R1
    // lockup escape for polynomial patterns only
    assign fb       = fb_raw | (~g.rep & ~|sr_q[30:0]);                     // R14
    assign g.out_bit = fb | (g.qrss & ~|sr_q[13:0]);                        // R13
    assign shift_in = g.use_ext ? g.ext_bit : fb;
    assign sr_d     = g.load ? g.seed
                    : g.step ? {sr_q[30:0], shift_in}
                    :          sr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= 32'h0000_0000;
        end else begin
            sr_q <= sr_d;
        end
    end
endmodule : bert_pgen

// ==== sim/bert_top_sva.sv ====
// Purpose: port-level assertions for the tester
// Assumes: one clock domain, pclk
// Notes:   bound into bert_top below
`timescale 1ns/1ps
module bert_top_sva
    import bert_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_bit_req,
    input wire logic        tx_bit_valid,
    input wire logic        tx_bit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ans; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    a_ans: assert property (p_ans) else $error("answer timing");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_qual; pready |-> psel && penable; endproperty
    a_qual: assert property (p_qual) else $error("ready outside access");
    property p_map; pready |-> pslverr == (paddr > OFS_ERR_CNT || paddr[1:0] != 2'h0); endproperty
    a_map: assert property (p_map) else $error("address decode");
    property p_err0; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
    a_err0: assert property (p_err0) else $error("refused read data");
    property p_txv; tx_bit_req |=> tx_bit_valid; endproperty
    a_txv: assert property (p_txv) else $error("tx bit missing");
    property p_txq; tx_bit_valid |-> $past(tx_bit_req); endproperty
    a_txq: assert property (p_txq) else $error("tx bit unasked");
    property p_hold; !tx_bit_req |=> $stable(tx_bit); endproperty
    a_hold: assert property (p_hold) else $error("tx bit moved");
    c_err: cover property (pready && pslverr);
    c_wr: cover property (pready && pwrite);
    c_run: cover property (tx_bit_valid [*3]);
endmodule : bert_top_sva
bind bert_top bert_top_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .tx_bit_req, .tx_bit_valid, .tx_bit);

// ==== sim/bert_link.sv ====
// Purpose: payload datapath model, loops tx bits back to rx
// Assumes: one bit slot per request
// Notes:   idle rx line toggles so stale data never looks valid
`timescale 1ns/1ps
module bert_link (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hold,
    input  wire logic tx_bit_valid,
    input  wire logic tx_bit,
    output logic      tx_bit_req,
    output logic      rx_bit_valid,
    output logic      rx_bit
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_bit_req   <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_bit       <= 1'b0;
        end else begin
            tx_bit_req   <= !hold;
            rx_bit_valid <= tx_bit_valid;
            rx_bit       <= tx_bit_valid ? tx_bit : !rx_bit;
        end
    end
endmodule : bert_link

// ==== sim/tb_bit_error_rate_tester.sv ====
// Purpose: self-checking bench for the bit error rate tester
// Assumes: link model loops transmit back to receive
// Notes:   each access notes its expected answer in a queue
`timescale 1ns/1ps
module tb_bit_error_rate_tester
    import bert_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0, r = 8'h0a;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, pmu_update = 1'b0, manual_error_input_pin = 1'b0;
    logic        tx_bit_req, tx_bit_valid, tx_bit, rx_bit_valid, rx_bit, irq;
    logic [64:0] q[$], n;
    int          num_errors = 0, check_count = 0, txdiff = 0, base;
    bert_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .datapath_reset(1'b0), .pmu_update, .manual_error_input_pin,
        .tx_bit_req, .tx_bit_valid, .tx_bit, .rx_bit_valid, .rx_bit, .irq);
    bert_link u_link (.pclk, .presetn, .hold(r[0]), .tx_bit_valid, .tx_bit, .tx_bit_req,
        .rx_bit_valid, .rx_bit);
    always #5 pclk = ~pclk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    always @(posedge pclk) r <= lfsr(r);
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [64:0] e);
        q.push_back(e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 65'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, 32'hffffffff, d});
    endtask : rd
    task automatic bits(input int k);
        repeat (k) @(posedge pclk iff tx_bit_valid);
    endtask : bits
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    // monitor: pops the oldest note at each answer
    always @(posedge pclk) begin
        if (pready) begin
            n = q.pop_front();
            chk("pslverr", {31'h0, n[64]}, {31'h0, pslverr});
            chk("prdata", n[31:0], prdata & n[63:32]);
        end
        if (tx_bit_valid && tx_bit !== 1'b1) txdiff <= txdiff + 1;
    end
    initial begin
        #500us;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_SEED_LO, 32'h0000ffff);
        rd(OFS_TST_STS, 32'h2);
        apb(1'b0, 8'h28, 32'h0, {1'b1, 32'hffffffff, 32'h0});
        wr(OFS_PAT_CTL, 32'h20);
        wr(OFS_PORT_CTL, 32'h1);
        wr(OFS_TST_CTL, 32'h3);
        bits(100);
        rd(OFS_TST_STS, 32'h0);
        pmu_update <= 1'b1;
        @(posedge pclk);
        pmu_update <= 1'b0;
        base = txdiff;
        wr(OFS_TST_CTL, 32'h23);
        bits(20);
        wr(OFS_TST_CTL, 32'h23);
        bits(20);
        wr(OFS_TST_CTL, 32'h43);
        manual_error_input_pin <= 1'b1;
        bits(20);
        chk("tx errors", 32'd3, 32'(txdiff - base));
        wr(OFS_TST_CTL, 32'h53);
        rd(OFS_ERR_CNT, 32'h3);
        rd(OFS_TST_STS, 32'h1);
        wr(OFS_INT_STS, 32'hf);
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_TST_CTL, 32'h153);
        bits(2);
        base = txdiff;
        bits(200);
        chk("rate errors", 32'd20, 32'(txdiff - base));
        chk("irq", 32'h1, {31'h0, irq});
        rd(OFS_TST_STS, 32'h3);
        wr(OFS_INT_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_INT_STS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(OFS_PAT_CTL, 32'h408);
        wr(OFS_TST_CTL, 32'h50);
        wr(OFS_TST_CTL, 32'h53);
        bits(200);
        rd(OFS_TST_STS, 32'h1);
        stop_test();
    end
endmodule : tb_bit_error_rate_tester
